// ### hw/dcp_consts.vh
// constants of the periodic collection channel register block
`ifndef DCP_CONSTS_VH
`define DCP_CONSTS_VH
// register addresses, offset within a channel
`define DCP_A_SLOT0 7'h02
`define DCP_A_SLOT1 7'h04
`define DCP_A_SLOT2 7'h06
`define DCP_A_SLOT3 7'h08
`define DCP_A_PCTRL 7'h0A
`define DCP_A_CHCTL 7'h0B
`define DCP_A_WIPE 7'h0E
`define DCP_CH1_BASE 7'h10
`define DCP_WIPE_KEY 8'hFF
// periodic collection control byte
`define DCP_PC_MAN 0
`define DCP_PC_AUTO 1
`define DCP_PC_EN 2
// channel control byte
`define DCP_CC_BCK0 0
`define DCP_CC_BCK1 1
`define DCP_CC_EN 2
`define DCP_CC_MTEST 3
// status byte
`define DCP_ST_UV 0
`define DCP_ST_TS 2
`define DCP_ST_OC 3
`define DCP_ST_GD 4
`define DCP_ST_GA 5
`define DCP_ST_CR 6
`define DCP_ST_PL 7
`define DCP_ST_MASK 8'hFD
// sample high byte fields
`define DCP_HB_FAULT 7
`define DCP_HB_PEND 5
`define DCP_HB_UV 4
// memory word: {fault, low supply, 20-bit sample}
`define DCP_MW_FAULT 21
`define DCP_MW_UV 20
`define DCP_SID_HI 19
`define DCP_SID_LO 16
// spi frame
`define DCP_FRAME_BITS 6'h20
`define DCP_ADDR_BITS 6'h08
`define DCP_FR_WR 31
// timing
`define DCP_CLK_MHZ 40
`define DCP_STEP_NS 500
`define DCP_STEP_CYC (`DCP_STEP_NS * `DCP_CLK_MHZ / 1000)
`define DCP_AUTO_US 500
`define DCP_AUTO_CYC (`DCP_AUTO_US * `DCP_CLK_MHZ)
// synchroniser reset image: chip select idles high
`define DCP_SYNC_RST 10'h200
`endif

// ### hw/dcp_slot_mem.v
// per-slave receive buffer memory with registered read data
`timescale 1ns/1ps
module dcp_slot_mem #(
    parameter WIDTH = 22,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire clear_in,
    input wire wr_en_in,
    input wire [AW-1:0] wr_addr_in,
    input wire [WIDTH-1:0] wr_data_in,
    input wire [AW-1:0] rd_addr_in,
    output reg [WIDTH-1:0] rd_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    integer i;

    ////////////////////////////////////////////////////////////////////////
    // storage, zeroed on reset and on a channel wipe
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {WIDTH{1'b0}};
            end
        end else if (clear_in) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {WIDTH{1'b0}};
            end
        end else if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // read port
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= {WIDTH{1'b0}};
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule

// ### hw/dcp_channel_regs.v
// register logic of one periodic collection channel behind the spi port
//
// Contract
// RL1: sample high byte: fault bit7, pending bit5, low supply bit4, sample 19:16 low.
// RL2: sample bits 19:16 carry the source id, used as crc seed.
// RL3: fault flag set on crc fail, bad symbol or receiver disagreement.
// RL4: buffer low supply flag set when qualified supply low is reported.
// RL5: pending flag set whenever fresh slave data sits in the buffer.
// RL6: manual broadcast write sends one read, only in periodic mode, auto off.
// RL7: auto broadcast every 500 us; writes ignored outside periodic mode.
// RL8: periodic enable enters collection; blocks command traffic and configuration.
// RL9: periodic enable clears only through a channel wipe.
// RL10: broadcast reads delayed by delay field times 0.5 us steps.
// RL11: monitor test bit forces supply monitor low so low supply flags set.
// RL12: channel enable bit enables or disables channel when conditions allow.
// RL13: buffer check mode entered only when both check bits written together.
// RL14: check bits written with enable and pulse count win; others ignored.
// RL15: writing pulse count sends that many discovery pulses when allowed.
// RL16: status bit7 on pll unlock, bit6 on external clock out of range.
// RL17: status flags sticky, cleared only by writing zero to the bit.
// RL18: status bit5 analog ground open, bit4 digital ground open.
// RL19: status bit3 set on qualified overcurrent shutdown.
// RL20: status bit2 set on thermal limit.
// RL21: status bit0 on qualified supply low; bit1 reads zero.
// RL22: writing all ones to wipe byte resets all channel registers.
// RL23: one copy per channel, four identical slave buffers.
// RL24: unused bits read zero, ignore writes; all fields reset zero.
`timescale 1ns/1ps
`include "dcp_consts.vh"
module dcp_channel_regs #(
    parameter CHANNEL = 0,
    parameter AUTO_PERIOD = `DCP_AUTO_CYC,
    parameter AUTO_W = 16
) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire spi_sck_in,
    input wire spi_cs_n_in,
    input wire spi_mosi_in,
    output reg spi_miso_out,
    output reg spi_miso_oe_out,
    input wire rx_valid_in,
    input wire [1:0] rx_slot_in,
    input wire [19:0] rx_sample_in,
    input wire rx_crc_bad_in,
    input wire rx_symbol_bad_in,
    input wire rx_mismatch_in,
    input wire pll_unlock_in,
    input wire ext_clock_range_in,
    input wire analog_ground_open_in,
    input wire digital_ground_open_in,
    input wire overcurrent_in,
    input wire thermal_in,
    input wire bus_supply_low_in,
    output reg [3:0] crc_seed_out,
    output reg broadcast_read_out,
    output reg periodic_collection_mode_out,
    output reg channel_enable_out,
    output reg buffer_check_mode_out,
    output reg supply_monitor_test_out,
    output reg discovery_start_out,
    output reg [2:0] discovery_pulse_count_out
);
    localparam [6:0] BASE = (CHANNEL != 0) ? `DCP_CH1_BASE : 7'h00; // [RL23]
    localparam STEP_I = `DCP_STEP_CYC;
    localparam AUTO_I = AUTO_PERIOD - 1;
    localparam [12:0] STEP = STEP_I[12:0];
    localparam [AUTO_W-1:0] AUTO_LAST = AUTO_I[AUTO_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // three-stage synchronisers; a level counts once stages two and three agree
    wire [9:0] raw = {spi_cs_n_in, spi_sck_in, spi_mosi_in, pll_unlock_in, ext_clock_range_in,
        analog_ground_open_in, digital_ground_open_in, overcurrent_in, thermal_in, bus_supply_low_in};
    reg [9:0] sync1;
    reg [9:0] sync2;
    reg [9:0] sync3;
    reg [9:0] filt;
    localparam [9:0] SRST = `DCP_SYNC_RST;
    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : gen_sync
            always @(posedge ref_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    sync1[g] <= SRST[g];
                    sync2[g] <= SRST[g];
                    sync3[g] <= SRST[g];
                    filt[g] <= SRST[g];
                end else begin
                    sync1[g] <= raw[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                    if (sync2[g] == sync3[g]) begin
                        filt[g] <= sync3[g];
                    end
                end
            end
        end
    endgenerate
    wire cs_act = ~filt[9];
    wire sck = filt[8];
    wire mosi = filt[7];
    wire [6:0] fault_in = filt[6:0];

    ////////////////////////////////////////////////////////////////////////
    // spi frame: bit31 write, 30:24 address, three data bytes
    reg sck_prev;
    reg cs_prev;
    reg [31:0] rx_shift;
    reg [31:0] tx_shift;
    reg [5:0] bit_cnt;
    reg [6:0] addr;
    wire sck_rise = cs_act & sck & ~sck_prev;
    wire sck_fall = cs_act & ~sck & sck_prev;
    wire frame_end = cs_prev & ~cs_act;
    wire frame_ok = frame_end & (bit_cnt == `DCP_FRAME_BITS);
    wire wr_frame = frame_ok & rx_shift[`DCP_FR_WR];
    wire [6:0] fr_addr = rx_shift[30:24];
    wire [7:0] b2 = rx_shift[23:16];
    wire [7:0] b3 = rx_shift[15:8];
    wire [7:0] b4 = rx_shift[7:0];
    reg [23:0] rd_word;

    // shift registers and bit counter
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_prev <= 1'b0;
            cs_prev <= 1'b0;
            rx_shift <= 32'h00000000;
            tx_shift <= 32'h00000000;
            bit_cnt <= 6'h00;
            addr <= 7'h00;
            spi_miso_out <= 1'b0;
            spi_miso_oe_out <= 1'b0;
        end else begin
            sck_prev <= sck;
            cs_prev <= cs_act;
            spi_miso_oe_out <= cs_act;
            spi_miso_out <= tx_shift[31];
            if (frame_end) begin
                bit_cnt <= 6'h00;
                tx_shift <= {1'b0, fr_addr, rd_word}; // answer goes out in the next frame
            end else if (sck_rise) begin
                rx_shift <= {rx_shift[30:0], mosi};
                if (bit_cnt != `DCP_FRAME_BITS) begin
                    bit_cnt <= bit_cnt + 6'h01;
                end
                if (bit_cnt == `DCP_ADDR_BITS - 6'h01) begin
                    addr <= {rx_shift[5:0], mosi};
                end
            end else if (sck_fall) begin
                tx_shift <= {tx_shift[30:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    reg periodic_en;
    reg auto_bc;
    reg [7:0] bc_delay;
    reg [7:0] status;
    reg [3:0] pending;
    reg manual_trig;
    wire wipe = wr_frame & (fr_addr == BASE + `DCP_A_WIPE) & (b2 == `DCP_WIPE_KEY); // [RL22]
    wire wr_pc = wr_frame & (fr_addr == BASE + `DCP_A_PCTRL);
    wire wr_cc = wr_frame & (fr_addr == BASE + `DCP_A_CHCTL);
    wire both_bck = b2[`DCP_CC_BCK1] & b2[`DCP_CC_BCK0];
    wire uv_now = fault_in[0] | supply_monitor_test_out; // [RL11]
    wire [7:0] events = {fault_in[6], fault_in[5], fault_in[4], fault_in[3],
        fault_in[2], fault_in[1], 1'b0, uv_now};

    // periodic mode, broadcast, delay and channel control
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            periodic_en <= 1'b0;
            auto_bc <= 1'b0;
            bc_delay <= 8'h00;
            manual_trig <= 1'b0;
            channel_enable_out <= 1'b0;
            buffer_check_mode_out <= 1'b0;
            supply_monitor_test_out <= 1'b0;
            discovery_start_out <= 1'b0;
            discovery_pulse_count_out <= 3'h0;
            periodic_collection_mode_out <= 1'b0;
        end else if (wipe) begin
            periodic_en <= 1'b0; // [RL9] [RL22]
            auto_bc <= 1'b0;
            bc_delay <= 8'h00;
            manual_trig <= 1'b0;
            channel_enable_out <= 1'b0;
            buffer_check_mode_out <= 1'b0;
            supply_monitor_test_out <= 1'b0;
            discovery_start_out <= 1'b0;
            discovery_pulse_count_out <= 3'h0;
            periodic_collection_mode_out <= 1'b0;
        end else begin
            manual_trig <= 1'b0;
            discovery_start_out <= 1'b0;
            periodic_collection_mode_out <= periodic_en;
            if (wr_pc) begin
                if (b2[`DCP_PC_EN]) begin
                    periodic_en <= 1'b1; // [RL8] a zero never clears it [RL9]
                end
                if (periodic_en) begin
                    auto_bc <= b2[`DCP_PC_AUTO]; // [RL7]
                end
                if (periodic_en & ~auto_bc & b2[`DCP_PC_MAN]) begin
                    manual_trig <= 1'b1; // [RL6]
                end
                if (~periodic_en) begin
                    bc_delay <= b3; // configuration frozen in periodic mode [RL8]
                end
            end
            if (wr_cc & ~periodic_en) begin
                supply_monitor_test_out <= b2[`DCP_CC_MTEST];
                if (both_bck) begin
                    buffer_check_mode_out <= 1'b1; // [RL13] [RL14]
                end else begin
                    channel_enable_out <= b2[`DCP_CC_EN]; // [RL12]
                    discovery_pulse_count_out <= b3[2:0];
                    discovery_start_out <= (b3[2:0] != 3'h0) & channel_enable_out; // [RL15]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status, set wins over a write of zero
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status <= 8'h00;
        end else if (wipe) begin
            status <= 8'h00;
        end else if (wr_cc) begin
            status <= ((status & b4) | events) & `DCP_ST_MASK; // [RL17] [RL21] [RL24]
        end else begin
            status <= (status | events) & `DCP_ST_MASK; // [RL16] [RL18] [RL19] [RL20]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // broadcast read timing: auto period and trigger-to-send delay
    reg [AUTO_W-1:0] auto_cnt;
    reg auto_trig;
    reg dly_busy;
    reg [12:0] dly_cnt;
    wire [12:0] dly_load = {5'h00, bc_delay} * STEP; // [RL10]

    // auto broadcast period counter
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            auto_cnt <= {AUTO_W{1'b0}};
            auto_trig <= 1'b0;
        end else begin
            auto_trig <= 1'b0;
            if (~auto_bc | wipe) begin
                auto_cnt <= {AUTO_W{1'b0}};
            end else if (auto_cnt == AUTO_LAST) begin
                auto_cnt <= {AUTO_W{1'b0}};
                auto_trig <= 1'b1; // [RL7]
            end else begin
                auto_cnt <= auto_cnt + {{(AUTO_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // delay counter; a trigger while one is pending is dropped
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dly_busy <= 1'b0;
            dly_cnt <= 13'h0000;
            broadcast_read_out <= 1'b0;
        end else begin
            broadcast_read_out <= 1'b0;
            if (wipe) begin
                dly_busy <= 1'b0;
                dly_cnt <= 13'h0000;
            end else if (dly_busy) begin
                if (dly_cnt == 13'h0000) begin
                    dly_busy <= 1'b0;
                    broadcast_read_out <= 1'b1; // [RL10]
                end else begin
                    dly_cnt <= dly_cnt - 13'h0001;
                end
            end else if (manual_trig | auto_trig) begin
                dly_busy <= 1'b1;
                dly_cnt <= dly_load;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive buffers: store sample with flags, raise pending, pass seed
    wire [21:0] mem_rd;
    wire rx_fault = rx_crc_bad_in | rx_symbol_bad_in | rx_mismatch_in; // [RL3]
    wire [21:0] mem_wr = {rx_fault, uv_now, rx_sample_in}; // [RL4]
    wire [1:0] rd_slot = addr[2:1] - 2'h1;
    wire is_slot = (addr == BASE + `DCP_A_SLOT0) | (addr == BASE + `DCP_A_SLOT1) |
        (addr == BASE + `DCP_A_SLOT2) | (addr == BASE + `DCP_A_SLOT3);
    wire slot_read = frame_ok & ~rx_shift[`DCP_FR_WR] & is_slot & (fr_addr == addr);

    dcp_slot_mem #(
        .WIDTH(22),
        .DEPTH(4),
        .AW(2)
    ) u_mem (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .clear_in(wipe),
        .wr_en_in(rx_valid_in),
        .wr_addr_in(rx_slot_in),
        .wr_data_in(mem_wr),
        .rd_addr_in(rd_slot),
        .rd_data_out(mem_rd)
    );

    // pending flags, fresh data wins over the clearing read
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pending <= 4'h0;
            crc_seed_out <= 4'h0;
        end else if (wipe) begin
            pending <= 4'h0;
            crc_seed_out <= 4'h0;
        end else begin
            if (slot_read) begin
                pending[rd_slot] <= 1'b0;
            end
            if (rx_valid_in) begin
                pending[rx_slot_in] <= 1'b1; // [RL5]
                crc_seed_out <= rx_sample_in[`DCP_SID_HI:`DCP_SID_LO]; // [RL2]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data mux for the addressed register
    always @* begin
        rd_word = 24'h000000;
        if (is_slot) begin
            rd_word[23:16] = {mem_rd[`DCP_MW_FAULT], 1'b0, pending[rd_slot], mem_rd[`DCP_MW_UV],
                mem_rd[`DCP_SID_HI:`DCP_SID_LO]}; // [RL1]
            rd_word[15:0] = mem_rd[15:0];
        end else if (addr == BASE + `DCP_A_PCTRL) begin
            rd_word[23:16] = {5'h00, periodic_en, auto_bc, 1'b0};
            rd_word[15:8] = bc_delay;
        end else if (addr == BASE + `DCP_A_CHCTL) begin
            rd_word[23:16] = {4'h0, supply_monitor_test_out, channel_enable_out,
                buffer_check_mode_out, buffer_check_mode_out}; // [RL24]
            rd_word[15:8] = {5'h00, discovery_pulse_count_out};
            rd_word[7:0] = status;
        end
    end
endmodule

// ### dv/dcp_spi_host_model.sv
// spi host model that sends one 32-bit frame into the channel block per request
`timescale 1ns/1ps
module dcp_spi_host_model (
    input wire go_in,
    input wire [31:0] frame_in,
    input wire miso_in,
    output reg sck_out,
    output reg cs_n_out,
    output reg mosi_out,
    output reg done_out,
    output reg [31:0] rx_out
);
    integer i;
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
        done_out = 1'b0;
        rx_out = 32'h0;
    end
    // msb first at 200 ns per bit; data moves mid low phase so the synced edges see it settled
    always begin
        wait (go_in === 1'b1);
        #7 cs_n_out = 1'b0;
        #150;
        for (i = 31; i >= 0; i = i - 1) begin
            #50 mosi_out = frame_in[i];
            #50 sck_out = 1'b1;
            #100 rx_out = {rx_out[30:0], miso_in};
            sck_out = 1'b0;
        end
        #100 cs_n_out = 1'b1;
        mosi_out = ~mosi_out; // released line never shows the last bit
        #250 done_out = 1'b1;
        wait (go_in === 1'b0);
        done_out = 1'b0;
    end
endmodule

// ### dv/dcp_channel_regs_checker.sv
// concurrent checks on the ports of the channel register block
`timescale 1ns/1ps
module dcp_channel_regs_checker (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire spi_cs_n_in,
    input wire rx_valid_in,
    input wire [19:0] rx_sample_in,
    input wire [3:0] crc_seed_out,
    input wire broadcast_read_out,
    input wire periodic_collection_mode_out,
    input wire channel_enable_out,
    input wire buffer_check_mode_out,
    input wire supply_monitor_test_out,
    input wire discovery_start_out,
    input wire [2:0] discovery_pulse_count_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    wire [3:0] sid_w = rx_sample_in[19:16];
    ////////////////////////////////////////////////////////////////////////
    property p_bc_pulse;
        broadcast_read_out |=> !broadcast_read_out [*8];
    endproperty
    a_bc_pulse: assert property (p_bc_pulse) else $error("broadcast pulse too long");
    property p_bc_mode;
        broadcast_read_out |-> periodic_collection_mode_out;
    endproperty
    a_bc_mode: assert property (p_bc_mode) else $error("broadcast outside periodic mode");
    property p_seed;
        rx_valid_in |=> crc_seed_out == $past(sid_w);
    endproperty
    a_seed: assert property (p_seed) else $error("crc seed not source id");
    property p_pm_hold;
        $fell(periodic_collection_mode_out) |-> spi_cs_n_in && $past(spi_cs_n_in, 3);
    endproperty
    a_pm_hold: assert property (p_pm_hold) else $error("periodic mode left outside commit");
    property p_en_rise;
        $rose(channel_enable_out) |-> !periodic_collection_mode_out;
    endproperty
    a_en_rise: assert property (p_en_rise) else $error("enable changed in periodic mode");
    property p_mt_rise;
        $rose(supply_monitor_test_out) |-> !periodic_collection_mode_out;
    endproperty
    a_mt_rise: assert property (p_mt_rise) else $error("monitor test changed in periodic mode");
    property p_bcm_rise;
        $rose(buffer_check_mode_out) |-> (!periodic_collection_mode_out && !discovery_start_out) [*3];
    endproperty
    a_bcm_rise: assert property (p_bcm_rise) else $error("check mode entry wrong");
    property p_ds;
        discovery_start_out |-> channel_enable_out ##[0:1] discovery_pulse_count_out != 3'h0;
    endproperty
    a_ds: assert property (p_ds) else $error("discovery start without enable or count");
    property p_rst;
        disable iff (1'b0) !reset_n_in |-> !broadcast_read_out && !periodic_collection_mode_out
            && !channel_enable_out && crc_seed_out == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("output not zero in reset");
    c_bc: cover property (broadcast_read_out);
    c_ds: cover property (discovery_start_out);
    c_bcm: cover property ($rose(buffer_check_mode_out));
endmodule
bind dcp_channel_regs dcp_channel_regs_checker dcp_channel_regs_checker_inst (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .spi_cs_n_in(spi_cs_n_in), .rx_valid_in(rx_valid_in),
    .rx_sample_in(rx_sample_in), .crc_seed_out(crc_seed_out), .broadcast_read_out(broadcast_read_out),
    .periodic_collection_mode_out(periodic_collection_mode_out), .channel_enable_out(channel_enable_out),
    .buffer_check_mode_out(buffer_check_mode_out), .supply_monitor_test_out(supply_monitor_test_out),
    .discovery_start_out(discovery_start_out), .discovery_pulse_count_out(discovery_pulse_count_out));

// ### dv/dcp_channel_regs_test.sv
// register level test of one periodic collection channel through its spi port
`timescale 1ns/1ps
`include "dcp_consts.vh"
module dcp_channel_regs_test;
    localparam AUTO_P = 200;
    reg clk, rst_n, go, rv, cb, sb, mb;
    reg [31:0] frame;
    reg [1:0] rs;
    reg [19:0] smp;
    reg [6:0] flt;
    reg [3:0] sid;
    reg [23:0] d;
    wire sck, cs_n, mosi, miso, oe, done, bc, pm, en, buffer_check_mode, mt, ds;
    wire [31:0] rx;
    wire [3:0] seed;
    wire [2:0] discovery_pulse_count;
    integer fails, cmp_count, cyc, bc_n, bc_cyc, cs_cyc, ds_n, k, t1, n;
    dcp_channel_regs #(.CHANNEL(0), .AUTO_PERIOD(AUTO_P), .AUTO_W(16)) dcp_channel_regs_inst (
        .ref_clk_in(clk), .reset_n_in(rst_n), .spi_sck_in(sck), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
        .spi_miso_out(miso), .spi_miso_oe_out(oe), .rx_valid_in(rv), .rx_slot_in(rs), .rx_sample_in(smp),
        .rx_crc_bad_in(cb), .rx_symbol_bad_in(sb), .rx_mismatch_in(mb), .pll_unlock_in(flt[6]),
        .ext_clock_range_in(flt[5]), .analog_ground_open_in(flt[4]), .digital_ground_open_in(flt[3]),
        .overcurrent_in(flt[2]), .thermal_in(flt[1]), .bus_supply_low_in(flt[0]), .crc_seed_out(seed),
        .broadcast_read_out(bc), .periodic_collection_mode_out(pm), .channel_enable_out(en),
        .buffer_check_mode_out(buffer_check_mode), .supply_monitor_test_out(mt), .discovery_start_out(ds),
        .discovery_pulse_count_out(discovery_pulse_count));
    dcp_spi_host_model dcp_spi_host_model_inst (.go_in(go), .frame_in(frame), .miso_in(miso),
        .sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .done_out(done), .rx_out(rx));
    ////////////////////////////////////////////////////////////////////////
    // clock and event counters
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (bc === 1'b1) begin
            bc_n <= bc_n + 1;
            bc_cyc <= cyc;
        end
        if (ds === 1'b1) ds_n <= ds_n + 1;
    end
    always @(posedge cs_n) cs_cyc = cyc;
    task report_and_stop;
        begin
            $display("mismatches %0d compares %0d", fails, cmp_count);
            if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input [23:0] got, input [23:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
                fails = fails + 1;
            end
        end
    endtask
    task chkr(input integer got, input integer lo, input integer hi);
        begin
            cmp_count = cmp_count + 1;
            if ((got >= lo && got <= hi) !== 1'b1) begin
                $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
                fails = fails + 1;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // spi frames, receive pulses and bounded waits
    task xfer(input [31:0] f);
        begin
            frame = f;
            go = 1'b1;
            for (n = 0; n < 2000 && done !== 1'b1; n = n + 1) @(negedge clk);
            chk({done, oe}, 2'b10);
            go = 1'b0;
            repeat (60) @(negedge clk);
        end
    endtask
    task wr(input [6:0] a, input [7:0] b2, input [7:0] b3, input [7:0] b4);
        xfer({1'b1, a, b2, b3, b4});
    endtask
    task rd(input [6:0] a);
        begin
            xfer({1'b0, a, 24'h0});
            xfer({1'b0, 7'h7F, 24'h0});
            d = rx[23:0];
        end
    endtask
    task rxp(input [1:0] s, input [19:0] v, input [2:0] b);
        begin
            rs = s;
            smp = v;
            {cb, sb, mb} = b;
            rv = 1'b1;
            @(negedge clk);
            rv = 1'b0;
            {cb, sb, mb} = 3'b000;
            @(negedge clk);
        end
    endtask
    task wait_bc(input integer target);
        for (n = 0; n < 1000 && bc_n < target; n = n + 1) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, go, rv, cb, sb, mb, rs, smp, flt, frame} = 0;
        {fails, cmp_count, cyc, bc_n, bc_cyc, cs_cyc, ds_n} = 0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        rd(`DCP_A_PCTRL); chk(d, 24'h0);
        rd(`DCP_A_CHCTL); chk(d, 24'h0);
        rd(7'h7F); chk(d, 24'h0);
        wr(`DCP_A_PCTRL, 8'h03, 8'h00, 8'h00);
        rd(`DCP_A_PCTRL); chk(d, 24'h0);
        chk(bc_n, 0);
        // one sample per slave, slaves 1 to 3 each with a different receive fault, slave 0 clean
        for (k = 0; k < 4; k = k + 1) begin
            sid = k + 9;
            rxp(k, {sid, 8'h5A, k[7:0]}, (k == 0) ? 3'b000 : 3'b100 >> (k - 1));
            chk(seed, sid);
        end
        for (k = 0; k < 4; k = k + 1) begin
            sid = k + 9;
            rd(`DCP_A_SLOT0 + 2 * k); chk(d, {(k != 0), 3'b010, sid, 8'h5A, k[7:0]});
        end
        rd(`DCP_A_SLOT0); chk(d, 24'h095A00);
        // faults go sticky in status and low supply marks the buffer
        flt = 7'h7F;
        repeat (8) @(negedge clk);
        rxp(1, 20'h31234, 3'b000);
        flt = 7'h00;
        repeat (8) @(negedge clk);
        rd(`DCP_A_SLOT1); chk(d, 24'h331234);
        rd(`DCP_A_CHCTL); chk(d, 24'h0000FD);
        wr(`DCP_A_CHCTL, 8'h00, 8'h00, 8'hFC);
        rd(`DCP_A_CHCTL); chk(d, 24'h0000FC);
        wr(`DCP_A_CHCTL, 8'h00, 8'h00, 8'h00);
        rd(`DCP_A_CHCTL); chk(d, 24'h0);
        // channel control fields and their priority
        wr(`DCP_A_CHCTL, 8'h04, 8'h00, 8'hFF); chk(en, 1'b1);
        wr(`DCP_A_CHCTL, 8'h04, 8'h03, 8'hFF); chk({ds_n[7:0], 5'h0, discovery_pulse_count}, 16'h0103);
        wr(`DCP_A_CHCTL, 8'h05, 8'h03, 8'hFF); chk(buffer_check_mode, 1'b0);
        wr(`DCP_A_CHCTL, 8'h03, 8'h06, 8'hFF); chk({buffer_check_mode, en, discovery_pulse_count}, 5'h1B);
        wr(`DCP_A_CHCTL, 8'h0C, 8'h00, 8'hFF); chk(mt, 1'b1);
        rxp(2, 20'h40001, 3'b000);
        rd(`DCP_A_SLOT2); chk(d[23:16], 8'h34);
        rd(`DCP_A_CHCTL); chk(d[7:0], 8'h01);
        wr(`DCP_A_WIPE, 8'hFF, 8'h00, 8'h00); chk({en, mt, buffer_check_mode}, 3'h0);
        rd(`DCP_A_CHCTL); chk(d, 24'h0);
        // periodic mode with a two-step broadcast delay
        wr(`DCP_A_PCTRL, 8'h00, 8'h02, 8'h00);
        wr(`DCP_A_PCTRL, 8'h04, 8'h02, 8'h00); chk(pm, 1'b1);
        wr(`DCP_A_PCTRL, 8'h04, 8'h03, 8'h00);
        wr(`DCP_A_CHCTL, 8'h0C, 8'h05, 8'hFF); chk({en, mt, discovery_pulse_count}, 5'h0);
        rd(`DCP_A_PCTRL); chk(d, 24'h040200);
        wr(`DCP_A_PCTRL, 8'h05, 8'h02, 8'h00); chk(bc_n, 1);
        chkr(bc_cyc - cs_cyc, 2 * `DCP_STEP_CYC + 6, 2 * `DCP_STEP_CYC + 9);
        wr(`DCP_A_PCTRL, 8'h06, 8'h02, 8'h00);
        wait_bc(2);
        t1 = bc_cyc;
        wait_bc(3);
        chk(bc_cyc - t1, AUTO_P);
        wr(`DCP_A_PCTRL, 8'h00, 8'h00, 8'h00); chk(pm, 1'b1);
        wr(`DCP_A_WIPE, 8'hFF, 8'h00, 8'h00); chk(pm, 1'b0);
        rd(`DCP_A_PCTRL); chk(d, 24'h0);
        report_and_stop;
    end
    // watchdog over the whole run
    initial begin
        #(25 * 60000);
        fails = fails + 1;
        report_and_stop;
    end
endmodule
